// ---- inc/isx_regs.svh ----
// Constants for the increment-skip and literal-OR execution block
// ----------------------------------------------------------------------
// Summary of operation
// - Opcode 0100 10da ffff ffff adds one to the addressed file register and leaves the flags alone.
// - Destination bit 0 sends the incremented value to the accumulator, 1 writes it back to the file register.
// - A nonzero incremented value discards the fetched next instruction and runs an idle cycle instead.
// - Bank bit 0 picks the fixed access bank, 1 takes the bank from the bank select register.
// - With the extended set on and bank bit 0, an operand address of 95 (5Fh) or below is an indexed literal offset.
// - The increment-and-skip takes one cycle, two when skipping, three when skipping a two-word instruction.
// - Each skipped word costs one full four-phase idle cycle, so a two-word skip gives two idle cycles.
// - Opcode 0000 1001 kkkk kkkk ORs the literal into the accumulator and updates negative and zero flags.
// ----------------------------------------------------------------------
`ifndef ISX_REGS_SVH
`define ISX_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ISX_OFS_CTRL      8'h00
`define ISX_OFS_BANK      8'h04
`define ISX_OFS_ACC       8'h08
`define ISX_OFS_STATUS    8'h0c
`define ISX_OFS_IDX       8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ISX_CTRL_EXT_BIT  0
`define ISX_STAT_Z_BIT    0
`define ISX_STAT_N_BIT    1
`define ISX_RST_ACC       8'h00
`define ISX_RST_BANK      4'h0
`define ISX_RST_IDX       12'h000

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
`define ISX_OPC_INC       6'h12
`define ISX_OPC_OR        8'h09
`define ISX_D_BIT         9
`define ISX_A_BIT         8
`define ISX_LIT_OFS_MAX   8'h5f
`define ISX_ACC_HI_LIM    8'h80
`define ISX_ACC_HI_BANK   4'hf
`define ISX_TW_MOVE       4'hc
`define ISX_TW_CALL0      8'hec
`define ISX_TW_CALL1      8'hed
`define ISX_TW_LOADFSR    8'hee
`define ISX_TW_GOTO       8'hef

`endif

// ---- inc/isx_pkg.sv ----
// Types shared by the increment-skip and literal-OR execution block
`include "isx_regs.svh"

package isx_pkg;

    // ------------------------------------------------------------------
    // Phase and operation encodings
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ISX_Q1 = 4'b0001,
        ISX_Q2 = 4'b0010,
        ISX_Q3 = 4'b0100,
        ISX_Q4 = 4'b1000
    } isx_phase_t;

    typedef enum logic [2:0] {
        ISX_OP_NONE = 3'b001,
        ISX_OP_INC  = 3'b010,
        ISX_OP_OR   = 3'b100
    } isx_op_t;

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    typedef struct packed {
        isx_phase_t  phase;
        isx_op_t     op;
        logic [15:0] instr;
        logic [7:0]  acc;
        logic        flag_n;
        logic        flag_z;
        logic [3:0]  bank;
        logic        ext_en;
        logic [11:0] idx_base;
        logic        skip;
        logic        skip2;
        logic [7:0]  result;
        logic        res_n;
        logic        res_z;
        logic        mem_rd;
        logic        mem_wr;
        logic [11:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic [7:0]  rdata;
        logic        idle;
    } isx_state_t;

    // Words that take a second program word
    function automatic logic isx_two_word(input logic [15:0] w);
        isx_two_word = (w[15:12] == `ISX_TW_MOVE)
                    || (w[15:8] == `ISX_TW_CALL0)
                    || (w[15:8] == `ISX_TW_CALL1)
                    || (w[15:8] == `ISX_TW_LOADFSR)
                    || (w[15:8] == `ISX_TW_GOTO);
    endfunction : isx_two_word

endpackage : isx_pkg

// ---- inc/isx_dp_if.sv ----
// Datapath signals between the core, the ALU and the address generator
`timescale 1ns/1ps

interface isx_dp_if;
    import isx_pkg::*;

    isx_op_t     op;
    logic [7:0]  opnd;
    logic [7:0]  acc;
    logic [7:0]  lit;
    logic [7:0]  result;
    logic        zero;
    logic        neg;
    logic [7:0]  f;
    logic        a_bit;
    logic [3:0]  bank;
    logic        ext_en;
    logic [11:0] idx_base;
    logic [11:0] addr;

    modport core (output op, opnd, acc, lit, f, a_bit, bank, ext_en,
                  idx_base,
                  input  result, zero, neg, addr);
    modport alu  (input  op, opnd, acc, lit,
                  output result, zero, neg);
    modport agen (input  f, a_bit, bank, ext_en, idx_base,
                  output addr);
endinterface : isx_dp_if

// ---- verilog/isx_alu.sv ----
// Increment and OR arithmetic with result flags
`timescale 1ns/1ps

module isx_alu
    import isx_pkg::*;
(
    isx_dp_if.alu dp
);

    // ------------------------------------------------------------------
    // Process data
    // ------------------------------------------------------------------
    always_comb begin
        case (dp.op)
            ISX_OP_INC: dp.result = 8'(dp.opnd + 8'h01);
            ISX_OP_OR:  dp.result = dp.acc | dp.lit;
            default:    dp.result = 8'h00;
        endcase
    end

    assign dp.zero = (dp.result == 8'h00);
    assign dp.neg  = dp.result[7];

endmodule : isx_alu

// ---- verilog/isx_agen.sv ----
// Operand address generation from bank bit, bank and literal offset
`timescale 1ns/1ps
`include "isx_regs.svh"

module isx_agen
    import isx_pkg::*;
(
    isx_dp_if.agen dp
);

    // ------------------------------------------------------------------
    // Address select
    // ------------------------------------------------------------------
    always_comb begin
        if (dp.a_bit) begin
            dp.addr = {dp.bank, dp.f};
        end else if (dp.ext_en && dp.f <= `ISX_LIT_OFS_MAX) begin
            dp.addr = 12'(dp.idx_base + {4'h0, dp.f});
        end else if (dp.f >= `ISX_ACC_HI_LIM) begin
            dp.addr = {`ISX_ACC_HI_BANK, dp.f};
        end else begin
            dp.addr = {4'h0, dp.f};
        end
    end

endmodule : isx_agen

// ---- verilog/isx_core.sv ----
// Four-phase decoder and executor for increment-skip and literal-OR
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "isx_regs.svh"

module isx_core
    import isx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Instruction fetch
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    output      logic        instr_take,
    output      logic        idle_cycle,
    // Data memory
    output      logic        mem_rd,
    output      logic        mem_wr,
    output      logic [11:0] mem_addr,
    output      logic [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [31:0] reg_rdata
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    isx_state_t st_reg;
    isx_state_t st_next;
    isx_dp_if   dp ();

    assign dp.op       = st_reg.op;
    assign dp.opnd     = mem_rdata;
    assign dp.acc      = st_reg.acc;
    assign dp.lit      = st_reg.instr[7:0];
    assign dp.f        = instr_word[7:0];
    assign dp.a_bit    = instr_word[`ISX_A_BIT];
    assign dp.bank     = st_reg.bank;
    assign dp.ext_en   = st_reg.ext_en;
    assign dp.idx_base = st_reg.idx_base;

    isx_alu u_alu (
        .dp (dp.alu)
    );

    isx_agen u_agen (
        .dp (dp.agen)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next        = st_reg;
        st_next.mem_rd = 1'b0;
        st_next.mem_wr = 1'b0;
        st_next.rdata  = 8'h00;

        // Software writes
        if (reg_wr) begin
            case (reg_addr)
                `ISX_OFS_CTRL: st_next.ext_en   = reg_wdata[`ISX_CTRL_EXT_BIT];
                `ISX_OFS_BANK: st_next.bank     = reg_wdata[3:0];
                `ISX_OFS_ACC:  st_next.acc      = reg_wdata[7:0];
                `ISX_OFS_IDX:  st_next.idx_base = reg_wdata[11:0];
                default:       st_next.ext_en   = st_reg.ext_en;
            endcase
        end

        // Software reads, data stands the next cycle
        if (reg_rd) begin
            case (reg_addr)
                `ISX_OFS_CTRL:   st_next.rdata = {7'h00, st_reg.ext_en};
                `ISX_OFS_BANK:   st_next.rdata = {4'h0, st_reg.bank};
                `ISX_OFS_ACC:    st_next.rdata = st_reg.acc;
                `ISX_OFS_STATUS: st_next.rdata = {6'h00, st_reg.flag_n,
                                                  st_reg.flag_z};
                `ISX_OFS_IDX:    st_next.rdata = st_reg.idx_base[7:0];
                default:         st_next.rdata = 8'h00;
            endcase
        end

        // Instruction phases
        case (st_reg.phase)
            ISX_Q1: begin
                st_next.phase = ISX_Q2;
                st_next.op    = ISX_OP_NONE;
                st_next.idle  = 1'b1;
                if (st_reg.skip) begin
                    // Discarded word; a two-word one costs one more
                    st_next.skip  = 1'b0;
                    st_next.skip2 = isx_two_word(instr_word);
                end else if (st_reg.skip2) begin
                    st_next.skip2 = 1'b0;
                end else if (instr_valid) begin
                    st_next.instr = instr_word;
                    st_next.idle  = 1'b0;
                    if (instr_word[15:10] == `ISX_OPC_INC) begin
                        st_next.op       = ISX_OP_INC;
                        st_next.mem_rd   = 1'b1;
                        st_next.mem_addr = dp.addr;
                    end else if (instr_word[15:8] == `ISX_OPC_OR) begin
                        st_next.op = ISX_OP_OR;
                    end
                end
            end
            ISX_Q2: begin
                st_next.phase = ISX_Q3;
            end
            ISX_Q3: begin
                st_next.phase  = ISX_Q4;
                st_next.result = dp.result;
                st_next.res_n  = dp.neg;
                st_next.res_z  = dp.zero;
                if (st_reg.op == ISX_OP_INC &&
                    st_reg.instr[`ISX_D_BIT]) begin
                    st_next.mem_wr    = 1'b1;
                    st_next.mem_wdata = dp.result;
                end
            end
            ISX_Q4: begin
                st_next.phase = ISX_Q1;
                case (st_reg.op)
                    ISX_OP_INC: begin
                        // Flags stay as they are
                        if (!st_reg.instr[`ISX_D_BIT]) begin
                            st_next.acc = st_reg.result;
                        end
                        st_next.skip = !st_reg.res_z;
                    end
                    ISX_OP_OR: begin
                        st_next.acc    = st_reg.result;
                        st_next.flag_n = st_reg.res_n;
                        st_next.flag_z = st_reg.res_z;
                    end
                    default: begin
                        st_next.acc = st_next.acc;
                    end
                endcase
            end
            default: begin
                st_next.phase = ISX_Q1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg           <= '0;
            st_reg.phase     <= ISX_Q1;
            st_reg.op        <= ISX_OP_NONE;
            st_reg.acc       <= `ISX_RST_ACC;
            st_reg.bank      <= `ISX_RST_BANK;
            st_reg.idx_base  <= `ISX_RST_IDX;
            st_reg.idle      <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign instr_take = (st_reg.phase == ISX_Q1);
    assign idle_cycle = st_reg.idle;
    assign mem_rd     = st_reg.mem_rd;
    assign mem_wr     = st_reg.mem_wr;
    assign mem_addr   = st_reg.mem_addr;
    assign mem_wdata  = st_reg.mem_wdata;
    assign reg_rdata  = {24'h000000, st_reg.rdata};

endmodule : isx_core

// ---- verification/isx_core_properties.sv ----
// Port-level properties of the increment-skip and literal-OR core
`timescale 1ns/1ps

module isx_core_checker
    import isx_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [15:0] instr_word,
    input wire logic        instr_valid,
    input wire logic        instr_take,
    input wire logic        idle_cycle,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ------------------------------------------------------------------
    // Cycles since reset release, saturating
    // ------------------------------------------------------------------
    logic [1:0] up_reg;
    logic [1:0] up_next;

    always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) up_reg <= 2'h0;
        else up_reg <= up_next;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    take_spacing_a:
        assert property (instr_take && up_reg == 2'h3 |=>
            !instr_take [*3] ##1 instr_take) else $error("take spacing");
    rd_cause_a:
        assert property (mem_rd |-> $past(instr_take) && $past(instr_valid)
            && $past(instr_word[15:10]) == 6'h12) else $error("read cause");
    rd_single_a:
        assert property (mem_rd |=> !mem_rd [*3]) else $error("read pulse");
    wr_cause_a:
        assert property (mem_wr |-> $past(mem_rd, 2)) else $error("write");
    dest_sel_a:
        assert property (mem_rd |-> ##2 (mem_wr == $past(instr_word[9], 3)))
            else $error("destination");
    wdata_inc_a:
        assert property (mem_wr |-> mem_wdata == $past(mem_rdata) + 8'h01)
            else $error("increment");
    skip_idle_a:
        assert property (mem_rd ##1 mem_rdata != 8'hff |-> ##3
            idle_cycle [*4]) else $error("skip idle");
    access_high_a:
        assert property (mem_rd && !$past(instr_word[8]) && $past(instr_word[7])
            |-> mem_addr == {4'hf, $past(instr_word[7:0])})
            else $error("access bank");
    bank_low_a:
        assert property (mem_rd && $past(instr_word[8]) |->
            mem_addr[7:0] == $past(instr_word[7:0])) else $error("bank addr");
    rdata_zero_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
            else $error("read data");

    cover property (mem_wr);
    cover property (mem_rd ##1 mem_rdata == 8'hff);
    cover property (idle_cycle [*8]);
endmodule : isx_core_checker

bind isx_core isx_core_checker i_isx_core_checker (
    .mclk(mclk), .rstn(rstn), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_take(instr_take),
    .idle_cycle(idle_cycle), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ---- verification/tb_top.sv ----
// Self-checking bench for the increment-skip and literal-OR core
`timescale 1ns/1ps
`include "isx_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end

module tb_top;
    import isx_pkg::*;
    logic        mclk        = 1'b0;
    logic        rstn        = 1'b0;
    logic [15:0] instr_word  = 16'h0000;
    logic        instr_valid = 1'b0;
    logic [7:0]  mem_rdata   = 8'h00;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic        instr_take, idle_cycle, mem_rd, mem_wr;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [31:0] reg_rdata;
    logic [7:0]  mem [0:4095];
    int          errors      = 0;
    int          num_checks  = 0;
    int          idle_cnt    = 0;
    logic [15:0] tw_word [0:3] = '{16'hc000, 16'hec00, 16'hed00, 16'hee00};

    always #2 mclk = ~mclk;

    isx_core i_isx_core (.mclk(mclk), .rstn(rstn), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_take(instr_take),
        .idle_cycle(idle_cycle), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------------
    // Data memory, changing pattern when not read
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (mem_rd) mem_rdata <= mem[mem_addr];
        else mem_rdata <= ~mem_rdata;
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
    always @(negedge mclk) if (idle_cycle === 1'b1) idle_cnt++;

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        @(posedge mclk);
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [7:0] ex);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        `CHK("reg_rdata", {24'h0, ex}, reg_rdata)
        @(posedge mclk);
    endtask : reg_check

    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        instr_word  <= w;
        instr_valid <= 1'b1;
        do begin
            @(negedge mclk);
            n++;
        end while (instr_take !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        @(posedge mclk);
    endtask : issue

    task automatic settle();
        instr_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : settle

    task automatic test_done();
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial begin
        #20000;
        errors++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        reg_check(`ISX_OFS_ACC, `ISX_RST_ACC);
        reg_check(`ISX_OFS_STATUS, 8'h00);
        reg_check(8'h14, 8'h00);
        reg_write(`ISX_OFS_ACC, 32'h9a);
        issue(16'h0935);
        settle();
        reg_check(`ISX_OFS_ACC, 8'hbf);
        reg_check(`ISX_OFS_STATUS, 8'h02);
        reg_write(`ISX_OFS_ACC, 32'h0);
        issue(16'h0900);
        settle();
        reg_check(`ISX_OFS_STATUS, 8'h01);
        // Nonzero increment skips the next word
        mem[12'h210] = 8'h05;
        reg_write(`ISX_OFS_BANK, 32'h2);
        issue(16'h4b10);
        idle_cnt = 0;
        issue(16'h0901);
        settle();
        `CHK("idle", 4, idle_cnt)
        `CHK("mem", 8'h06, mem[12'h210])
        reg_check(`ISX_OFS_ACC, 8'h00);
        reg_check(`ISX_OFS_STATUS, 8'h01);
        // Zero result runs the next word
        mem[12'h211] = 8'hff;
        issue(16'h4b11);
        idle_cnt = 0;
        issue(16'h0935);
        settle();
        `CHK("idle", 0, idle_cnt)
        `CHK("mem", 8'h00, mem[12'h211])
        reg_check(`ISX_OFS_ACC, 8'h35);
        // Result to accumulator, flags untouched
        mem[12'h212] = 8'h7f;
        issue(16'h4912);
        issue(16'h09ff);
        settle();
        `CHK("mem", 8'h7f, mem[12'h212])
        reg_check(`ISX_OFS_ACC, 8'h80);
        reg_check(`ISX_OFS_STATUS, 8'h00);
        // Skip over a two-word instruction
        mem[12'h213] = 8'h00;
        issue(16'h4b13);
        idle_cnt = 0;
        issue(16'hef00);
        issue(16'h0901);
        issue(16'h0902);
        settle();
        `CHK("idle", 8, idle_cnt)
        reg_check(`ISX_OFS_ACC, 8'h82);
        // Skip over the other two-word encodings
        foreach (tw_word[i]) begin
            issue(16'h4b13);
            idle_cnt = 0;
            issue(tw_word[i]);
            issue(16'h0940);
            settle();
            `CHK("idle", 8, idle_cnt)
        end
        reg_check(`ISX_OFS_ACC, 8'h82);
        // Access bank and literal offset
        mem[12'hf90] = 8'hff;
        issue(16'h4a90);
        settle();
        `CHK("mem", 8'h00, mem[12'hf90])
        reg_write(`ISX_OFS_CTRL, 32'h1);
        reg_write(`ISX_OFS_IDX, 32'h300);
        mem[12'h35f] = 8'hff;
        mem[12'h060] = 8'hff;
        issue(16'h4a5f);
        settle();
        `CHK("mem", 8'h00, mem[12'h35f])
        issue(16'h4a60);
        settle();
        `CHK("mem", 8'h00, mem[12'h060])
        test_done();
    end
endmodule : tb_top
